/* design/rie_pkg.sv */
/*
  Shared constants and types for the counter interrupt-enable block.
  Assumes a 32-bit AHB-Lite register bus and one clock domain.
*/
package rie_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int IDX_W = 4;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_EN_CLR = 4'h6;
  localparam logic [3:0] IDX_EN_SET = 4'h7;
  localparam logic [3:0] IDX_FLAG = 4'h8;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WRAP = 7;
  localparam int BIT_SYNC = 6;
  localparam int BIT_MATCH1 = 1;
  localparam int BIT_MATCH0 = 0;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_WP_BIT = 7;
  localparam int NUM_SRC = 4;

  // ----------------------------------------------------------------
  // Reset values and per-mode masks of implemented enable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_TWO_MATCH = 8'hC3;
  localparam logic [7:0] MASK_ONE_MATCH = 8'hC1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COUNT32,
    MODE_COUNT16,
    MODE_CALENDAR
  } rie_mode_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } rie_bus_state_type;

  typedef struct packed {
    logic write;
    logic [3:0] idx;
  } rie_aphase_type;

  typedef struct packed {
    logic wrap;
    logic sync;
    logic match1;
    logic match0;
  } rie_src_type;

endpackage

/* design/rie_flag_unit.sv */
/*
  Per-source sticky flags and request gating.
  Assumes set pulses and the clear strobe come from logic on the same clock.
*/
`timescale 1ns/10ps
module rie_flag_unit #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Flag control
  input wire logic [N-1:0] i_set,
  input wire logic i_clr_all,
  input wire logic [N-1:0] i_en,
  // Results
  output logic [N-1:0] o_flags,
  output logic [N-1:0] o_req,
  output logic o_irq
);

  logic [N-1:0] flag_ff;
  logic [N-1:0] req_ff;
  logic irq_ff;
  logic [N-1:0] nxt_req;

  // ----------------------------------------------------------------
  // Per-source flag and request
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_src
      // Set wins over a read clear in the same cycle
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          flag_ff[g] <= 1'b0;
        end else begin
          flag_ff[g] <= i_set[g] | (flag_ff[g] & ~i_clr_all);
        end
      end
      assign nxt_req[g] = flag_ff[g] & i_en[g];
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          req_ff[g] <= 1'b0;
        end else begin
          req_ff[g] <= nxt_req[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |nxt_req;
    end
  end

  assign o_flags = flag_ff;
  assign o_req = req_ff;
  assign o_irq = irq_ff;

endmodule

/* design/rie_top.sv */
/*
  Interrupt-enable set/clear registers of a real-time counter, with flag
  gating and one level interrupt, reached over an AHB-Lite slave port.
  Assumes the counter, the tick and the event pulses run on I_REF_CLK.
*/
`timescale 1ns/10ps
module rie_top (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Counter events
  input wire logic I_CNT_TICK,
  input wire logic I_WRAP_EVT,
  input wire logic I_SYNC_DONE_EVT,
  input wire logic [1:0] I_MATCH_EVT,
  // Interrupt outputs
  output logic [rie_pkg::NUM_SRC-1:0] O_IRQ_REQ,
  output logic O_IRQ,
  output logic [7:0] O_IRQ_EN
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rie_pkg::rie_bus_state_type state_ff;
  rie_pkg::rie_bus_state_type nxt_state;
  rie_pkg::rie_aphase_type aph_ff;
  rie_pkg::rie_aphase_type nxt_aph;
  logic hready_ff;
  logic nxt_hready;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic [7:0] en_ff;
  logic [7:0] nxt_en;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic pend_ff;
  logic nxt_pend;
  logic accept;
  logic wr_strobe;
  logic rd_strobe;
  logic wp_on;
  logic [1:0] mode;
  logic [7:0] mode_mask;
  logic [7:0] en_live;
  logic [7:0] wr_bits;
  logic [7:0] flag_view;
  rie_pkg::rie_src_type src_set;
  rie_pkg::rie_src_type src_en;
  logic [rie_pkg::NUM_SRC-1:0] flags;
  logic [rie_pkg::NUM_SRC-1:0] req;
  logic irq;
  logic flag_rd_clr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only NONSEQ/SEQ with the bus ready open an address phase.
  assign accept = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign wr_strobe = (state_ff == rie_pkg::BUS_WRITE);
  assign rd_strobe = (state_ff == rie_pkg::BUS_READ_WAIT);
  assign wr_bits = I_HWDATA[7:0];

  always_comb begin
    nxt_aph = aph_ff;
    if (accept) begin
      nxt_aph.write = I_HWRITE;
      nxt_aph.idx = I_HADDR[rie_pkg::ADDR_LSB +: rie_pkg::IDX_W];
      // Addresses above the register window decode to no register
      if (I_HADDR[31:rie_pkg::ADDR_LSB + rie_pkg::IDX_W] != '0) begin
        nxt_aph.idx = 4'hF;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      aph_ff <= '0;
    end else begin
      aph_ff <= nxt_aph;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  // Reads take one wait state so that a write completing in the
  // previous data phase is always visible to the read that follows.
  always_comb begin
    nxt_state = rie_pkg::BUS_IDLE;
    case (state_ff)
      rie_pkg::BUS_READ_WAIT: begin
        nxt_state = rie_pkg::BUS_READ_DONE;
      end
      rie_pkg::BUS_IDLE, rie_pkg::BUS_WRITE, rie_pkg::BUS_READ_DONE: begin
        if (accept) begin
          nxt_state = I_HWRITE ? rie_pkg::BUS_WRITE : rie_pkg::BUS_READ_WAIT;
        end
      end
      default: begin
        nxt_state = rie_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state_ff <= rie_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_hready = 1'b1;
    if (nxt_state == rie_pkg::BUS_READ_WAIT) begin
      nxt_hready = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      hready_ff <= 1'b1;
    end else begin
      hready_ff <= nxt_hready;
    end
  end

  // Every transfer, mapped or not, answers OKAY
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register: counter mode and write protection
  // ----------------------------------------------------------------
  assign mode = ctrl_ff[rie_pkg::CTRL_MODE_LSB +: rie_pkg::CTRL_MODE_W];
  assign wp_on = ctrl_ff[rie_pkg::CTRL_WP_BIT];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_strobe && aph_ff.idx == rie_pkg::IDX_CTRL) begin
      nxt_ctrl = wr_bits & (rie_pkg::CTRL_RST | 8'h83);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      ctrl_ff <= rie_pkg::CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Bit 1 only exists in the two-match mode; elsewhere bit 0 is the
  // single match or alarm source.
  always_comb begin
    mode_mask = rie_pkg::MASK_ONE_MATCH;
    case (mode)
      rie_pkg::MODE_COUNT16: begin
        mode_mask = rie_pkg::MASK_TWO_MATCH;
      end
      default: begin
        mode_mask = rie_pkg::MASK_ONE_MATCH;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Shared enable state
  // ----------------------------------------------------------------
  // Ones clear or set only their own bits; zeros leave state alone.
  always_comb begin
    nxt_en = en_ff;
    if (wr_strobe && !wp_on) begin
      if (aph_ff.idx == rie_pkg::IDX_EN_CLR) begin
        // Bits 7, 6 and the mode-dependent low bits
        nxt_en = en_ff & ~(wr_bits & mode_mask);
      end else if (aph_ff.idx == rie_pkg::IDX_EN_SET) begin
        // Bits 7, 6 and the mode-dependent low bits
        nxt_en = en_ff | (wr_bits & mode_mask);
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      en_ff <= rie_pkg::EN_RST;
    end else begin
      en_ff <= nxt_en;
    end
  end

  // A bit stored under another mode does not gate a source it lacks.
  assign en_live = en_ff & mode_mask;

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // Wrap and match events wait for the next count tick before their
  // flag rises; sync-done is a bus-side event and sets at once.
  always_comb begin
    nxt_pend = pend_ff | I_WRAP_EVT;
    if (I_CNT_TICK) begin
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  logic [1:0] match_pend_ff;
  logic [1:0] nxt_match_pend;

  always_comb begin
    nxt_match_pend = match_pend_ff | I_MATCH_EVT;
    if (I_CNT_TICK) begin
      nxt_match_pend = 2'b00;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      match_pend_ff <= 2'b00;
    end else begin
      match_pend_ff <= nxt_match_pend;
    end
  end

  always_comb begin
    src_set.wrap = I_CNT_TICK & (pend_ff | I_WRAP_EVT);
    src_set.sync = I_SYNC_DONE_EVT;
    src_set.match1 = I_CNT_TICK & (match_pend_ff[1] | I_MATCH_EVT[1])
      & mode_mask[rie_pkg::BIT_MATCH1];
    src_set.match0 = I_CNT_TICK & (match_pend_ff[0] | I_MATCH_EVT[0]);
  end

  always_comb begin
    src_en.wrap = en_live[rie_pkg::BIT_WRAP];
    src_en.sync = en_live[rie_pkg::BIT_SYNC];
    src_en.match1 = en_live[rie_pkg::BIT_MATCH1];
    src_en.match0 = en_live[rie_pkg::BIT_MATCH0];
  end

  // ----------------------------------------------------------------
  // Flags and request gating
  // ----------------------------------------------------------------
  assign flag_rd_clr = rd_strobe & (aph_ff.idx == rie_pkg::IDX_FLAG);

  rie_flag_unit #(
    .N(rie_pkg::NUM_SRC)
  ) u_flags (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_set(src_set),
    .i_clr_all(flag_rd_clr),
    .i_en(src_en),
    .o_flags(flags),
    .o_req(req),
    .o_irq(irq)
  );

  always_comb begin
    flag_view = 8'h00;
    flag_view[rie_pkg::BIT_WRAP] = flags[3];
    flag_view[rie_pkg::BIT_SYNC] = flags[2];
    flag_view[rie_pkg::BIT_MATCH1] = flags[1];
    flag_view[rie_pkg::BIT_MATCH0] = flags[0];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    if (rd_strobe) begin
      case (aph_ff.idx)
        rie_pkg::IDX_CTRL: begin
          nxt_hrdata = {24'h00_0000, ctrl_ff};
        end
        rie_pkg::IDX_EN_CLR, rie_pkg::IDX_EN_SET: begin
          nxt_hrdata = {24'h00_0000, en_live};
        end
        rie_pkg::IDX_FLAG: begin
          nxt_hrdata = {24'h00_0000, flag_view};
        end
        default: begin
          nxt_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Data is held until the next read replaces it
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_strobe) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [7:0] en_out_ff;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      en_out_ff <= rie_pkg::EN_RST;
    end else begin
      en_out_ff <= nxt_en & mode_mask;
    end
  end

  assign O_HRDATA = hrdata_ff;
  assign O_HREADYOUT = hready_ff;
  assign O_HRESP = hresp_ff;
  assign O_IRQ_REQ = req;
  assign O_IRQ = irq;
  assign O_IRQ_EN = en_out_ff;

endmodule

/* tb/rie_chk.sv */
/*
  Port-level checker for rie_top, bound to it below.
  Assumes one clock and a synchronous, active-high reset.
*/
`timescale 1ns/10ps
module rie_chk (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // Bus
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  // Events and interrupts
  input wire logic I_CNT_TICK,
  input wire logic I_WRAP_EVT,
  input wire logic [rie_pkg::NUM_SRC-1:0] O_IRQ_REQ,
  input wire logic O_IRQ,
  input wire logic [7:0] O_IRQ_EN
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic ctl_aph_ff;
  logic prot_ff;
  logic [1:0] mode_ff;
  logic [7:0] mask;
  // Shadow of the control word; protection never locks it
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      ctl_aph_ff <= 1'b0;
      prot_ff <= 1'b0;
      mode_ff <= 2'h0;
    end else begin
      ctl_aph_ff <= I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE && I_HADDR[31:2] == 30'h0;
      if (ctl_aph_ff) begin
        prot_ff <= I_HWDATA[7];
        mode_ff <= I_HWDATA[1:0];
      end
    end
  end
  assign mask = (mode_ff == 2'h1) ? rie_pkg::MASK_TWO_MATCH : rie_pkg::MASK_ONE_MATCH;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_take(logic wr, logic [29:0] idx);
    I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE == wr && I_HADDR[31:2] == idx;
  endsequence
  property p_set;
    s_take(1'b1, 30'h7) ##1 !prot_ff |=>
      O_IRQ_EN == (($past(O_IRQ_EN) | $past(I_HWDATA[7:0])) & mask);
  endproperty
  property p_clr;
    s_take(1'b1, 30'h6) ##1 !prot_ff |=> O_IRQ_EN == ($past(O_IRQ_EN) & ~$past(I_HWDATA[7:0]));
  endproperty
  property p_prot;
    (s_take(1'b1, 30'h6) or s_take(1'b1, 30'h7)) ##1 prot_ff |=> $stable(O_IRQ_EN);
  endproperty
  property p_read;
    (s_take(1'b0, 30'h6) or s_take(1'b0, 30'h7)) |=>
      !O_HREADYOUT ##1 (O_HREADYOUT && O_HRDATA == {24'h0, O_IRQ_EN});
  endproperty
  property p_wrap;
    I_WRAP_EVT && I_CNT_TICK && O_IRQ_EN[7] ##1 O_IRQ_EN[7] |=> O_IRQ_REQ[3];
  endproperty
  property p_gate;
    (O_IRQ_REQ & ~{$past(O_IRQ_EN[7]), $past(O_IRQ_EN[6]), $past(O_IRQ_EN[1]),
      $past(O_IRQ_EN[0])}) == 4'h0;
  endproperty
  property p_irq;
    O_IRQ == |O_IRQ_REQ;
  endproperty
  property p_okay;
    !O_HRESP;
  endproperty
  a_set: assert property (p_set) else $error("set write gave wrong enables");
  a_clr: assert property (p_clr) else $error("clear write gave wrong enables");
  a_prot: assert property (p_prot) else $error("protected write changed enables");
  a_read: assert property (p_read) else $error("enable read wrong");
  a_wrap: assert property (p_wrap) else $error("wrap request missing");
  a_gate: assert property (p_gate) else $error("request from disabled source");
  a_irq: assert property (p_irq) else $error("irq not the OR of requests");
  a_okay: assert property (p_okay) else $error("response not OKAY");
endmodule

bind rie_top rie_chk rie_chk_i (
  .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
  .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
  .I_CNT_TICK(I_CNT_TICK), .I_WRAP_EVT(I_WRAP_EVT), .O_IRQ_REQ(O_IRQ_REQ),
  .O_IRQ(O_IRQ), .O_IRQ_EN(O_IRQ_EN)
);

/* tb/rie_tb_top.sv */
/*
  Self-checking bench for rie_top: enable table, protection, gating, reset.
  Assumes the bound checker is compiled with it.
*/
`timescale 1ns/10ps
module rie_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tick = 1'b0;
  logic wrap = 1'b0;
  logic sync = 1'b0;
  logic [1:0] match = 2'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [3:0] req;
  logic irq;
  logic [7:0] en;
  logic [31:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // Mode, register index, write data, enables expected afterwards
  logic [21:0] rows [12] = '{
    {2'h1, 4'h7, 8'hFF, 8'hC3},
    {2'h1, 4'h6, 8'h00, 8'hC3},
    {2'h1, 4'h7, 8'h00, 8'hC3},
    {2'h1, 4'h6, 8'h80, 8'h43},
    {2'h1, 4'h6, 8'h40, 8'h03},
    {2'h1, 4'h6, 8'h02, 8'h01},
    {2'h1, 4'h6, 8'h01, 8'h00},
    {2'h0, 4'h7, 8'h01, 8'h01},
    {2'h2, 4'h7, 8'hC0, 8'hC1},
    {2'h2, 4'h6, 8'h01, 8'hC0},
    {2'h1, 4'h7, 8'h02, 8'hC2},
    {2'h0, 4'h6, 8'h00, 8'hC0}
  };

  always #12.5 clk = ~clk;

  rie_top rie_top_i (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_CNT_TICK(tick),
    .I_WRAP_EVT(wrap), .I_SYNC_DONE_EVT(sync), .I_MATCH_EVT(match), .O_IRQ_REQ(req),
    .O_IRQ(irq), .O_IRQ_EN(en)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] ra(input logic [3:0] idx);
    return {26'h0, idx, 2'b00};
  endfunction
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_irq(input string nm, input logic [4:0] exp);
    num_checks++;
    if ({req, irq} !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, {req, irq});
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Events held for one cycle together with a count tick
  task automatic pulse(input logic [3:0] ev);
    @(posedge clk);
    {wrap, sync, match} <= ev;
    tick <= 1'b1;
    @(posedge clk);
    {wrap, sync, match} <= 4'h0;
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      $display("run timed out");
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      bus(1'b1, ra(rie_pkg::IDX_CTRL), {30'h0, rows[k][21:20]});
      bus(1'b1, ra(rows[k][19:16]), {24'h0, rows[k][15:8]});
      bus(1'b0, ra(rie_pkg::IDX_EN_CLR), 32'h0);
      chk_word("clear register read", {24'h0, rows[k][7:0]}, rd);
      bus(1'b0, ra(rie_pkg::IDX_EN_SET), 32'h0);
      chk_word("set register read", {24'h0, rows[k][7:0]}, rd);
    end
    $display("enable table test done");
    bus(1'b1, ra(rie_pkg::IDX_CTRL), 32'h81);
    bus(1'b1, ra(rie_pkg::IDX_EN_SET), 32'hFF);
    bus(1'b1, ra(rie_pkg::IDX_EN_CLR), 32'hFF);
    settle();
    chk_word("protected enables", 32'hC2, {24'h0, en});
    bus(1'b1, ra(rie_pkg::IDX_CTRL), 32'h01);
    // Index 6 with address bit 6 set must not alias the clear register
    bus(1'b1, 32'h58, 32'hFF);
    bus(1'b0, 32'h58, 32'h0);
    chk_word("unmapped read", 32'h0, rd);
    chk_word("enables after unmapped write", 32'hC2, {24'h0, en});
    $display("protection test done");
    bus(1'b1, ra(rie_pkg::IDX_EN_CLR), 32'hFF);
    pulse(4'hF);
    chk_irq("disabled sources", 5'h00);
    bus(1'b1, ra(rie_pkg::IDX_EN_SET), 32'h80);
    settle();
    chk_irq("wrap request", 5'h11);
    bus(1'b1, ra(rie_pkg::IDX_EN_SET), 32'h43);
    settle();
    chk_irq("all requests", 5'h1F);
    bus(1'b1, ra(rie_pkg::IDX_EN_CLR), 32'hC3);
    settle();
    chk_irq("masked requests", 5'h00);
    bus(1'b0, ra(rie_pkg::IDX_FLAG), 32'h0);
    chk_word("flag read", 32'hC3, rd);
    bus(1'b1, ra(rie_pkg::IDX_EN_SET), 32'hC3);
    settle();
    chk_irq("flags cleared", 5'h00);
    pulse(4'h8);
    chk_irq("wrap after tick", 5'h11);
    bus(1'b0, ra(rie_pkg::IDX_FLAG), 32'h0);
    chk_word("wrap flag read", 32'h80, rd);
    // Wrap seen without a tick must wait for the next tick
    @(posedge clk);
    wrap <= 1'b1;
    @(posedge clk);
    wrap <= 1'b0;
    settle();
    chk_irq("wrap waits for tick", 5'h00);
    pulse(4'h0);
    chk_irq("wrap on late tick", 5'h11);
    bus(1'b1, ra(rie_pkg::IDX_CTRL), 32'h00);
    pulse(4'h2);
    bus(1'b0, ra(rie_pkg::IDX_FLAG), 32'h0);
    chk_word("match1 refused in mode 0", 32'h80, rd);
    $display("interrupt test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_word("enables after reset", 32'h0, {24'h0, en});
    chk_irq("requests after reset", 5'h00);
    bus(1'b0, ra(rie_pkg::IDX_EN_SET), 32'h0);
    chk_word("set register after reset", 32'h0, rd);
    $display("reset test done");
    wrap_up();
  end
endmodule
